// [hdl/mfpin_device.sv]
// device end: seven status/control pins, staging, straps, apb regs
// assumes the board end joins through mfpin_if; apb master on CLK_I
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
// Function
// - seven pins, each status output or control input
// - per-pin function register, bit7 role, code low
// - role bit one makes status output
// - role bit zero makes control input
// - during reset pins only inputs, levels latched after release
// - pins stay released until programmed or eeprom
// - pins 3,4 pulled low; pin3 high loads eeprom
// - pin4 high selects i2c, low spi
// - pins 6,5 pick i2c address 0x48..0x4B
// - outputs keep old function until update
// - update applies newly programmed functions
// - function write freezes controls until update
// - board may change input levels before update
// - board releases pin before input-to-output update
// - output-to-input goes through no-operation first
// - no-operation function releases pin, ignores level; with role bit one in mode 00/01 the pin is driven at its inactive level
// - board should not float input pins
// - mode 00 active high, 01 active low
// - mode 10/11 open drain high/low
// - strength bit one selects weak drive
// - control combine: or group, then and
// - inverted codes invert the pin level
module mfpin_device
    import mfpin_pkg::*;
(
    input wire logic CLK_I, // core clock
    input wire logic NRST_I, // sync reset, low active
    mfpin_if.device PINS, // pin bundle
    input wire logic PSEL_I, // apb select
    input wire logic PENABLE_I, // apb enable
    input wire logic PWRITE_I, // apb direction
    input wire logic [ADDR_W-1:0] PADDR_I, // apb byte address
    input wire logic [DATA_W-1:0] PWDATA_I, // apb write data
    output logic PREADY_O, // apb ready
    output logic [DATA_W-1:0] PRDATA_O, // apb read data
    output logic PSLVERR_O, // apb error, unmapped
    input wire logic [NFUNC-1:0] STATUS_I, // internal status sources
    output logic [NFUNC-1:0] CTRL_O, // control destinations
    input wire logic [NPIN-1:0] EE_OE_I, // eeprom master drive
    input wire logic [NPIN-1:0] EE_OUT_I, // eeprom master level
    output logic EEPROM_LOAD_O, // strap: load eeprom
    output logic I2C_MODE_O, // strap: i2c serial port
    output logic [6:0] I2C_ADDR_O, // strap: i2c address
    output logic STRAP_VALID_O // straps captured
);
    //--------------------------------------------------------------
    // registers: staged and active copies
    //--------------------------------------------------------------
    logic [7:0] fn_reg [NPIN];
    logic [7:0] fn_act [NPIN];
    logic [2*NPIN-1:0] mode_reg;
    logic [2*NPIN-1:0] mode_act;
    logic [NPIN-1:0] str_reg;
    logic [NPIN-1:0] str_act;
    logic [9:0] idx;
    logic access;
    logic wr_en;
    logic mapped;
    logic [DATA_W-1:0] rd_val;
    logic sw_update;
    logic fn_write;
    logic update;
    logic upd_pin_last;
    logic freeze;
    logic [NFUNC-1:0] comb;
    logic [NFUNC-1:0] status_vec;
    logic [NPIN-1:0] sync1, sync2, sync3, pin_val;
    logic [NPIN-1:0] dir_v, inv_v, or_v;
    logic [7:0] strap_cnt;

    assign idx = PADDR_I[ADDR_W-1:2];
    assign access = PSEL_I & PENABLE_I;
    assign wr_en = access & PREADY_O & PWRITE_I;
    assign fn_write = wr_en && idx >= IDX_FN_FIRST && idx <= IDX_FN_LAST;
    assign sw_update = wr_en && idx == IDX_UPDATE && PWDATA_I[0];

    //--------------------------------------------------------------
    // apb slave: one wait state so read data comes from a flop
    //--------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        rd_val = '0;
        if (idx == IDX_MODE_LO) begin
            rd_val[7:0] = mode_reg[7:0];
        end else if (idx == IDX_MODE_HI) begin
            rd_val[5:0] = mode_reg[2*NPIN-1:8];
        end else if (idx >= IDX_FN_FIRST && idx <= IDX_FN_LAST) begin
            rd_val[7:0] = fn_reg[3'(idx - IDX_FN_FIRST)];
        end else if (idx == IDX_STRENGTH) begin
            rd_val[NPIN-1:0] = str_reg;
        end else if (idx == IDX_UPDATE) begin
            rd_val = '0;
        end else if (idx == IDX_STATUS) begin
            rd_val[5:0] = {freeze, STRAP_VALID_O, I2C_MODE_O,
                EEPROM_LOAD_O, I2C_ADDR_O[1:0]};
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            PREADY_O <= 1'b0;
            PRDATA_O <= '0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= access & ~PREADY_O;
            PRDATA_O <= (access & ~PREADY_O & ~PWRITE_I) ? rd_val : '0;
            PSLVERR_O <= access & ~PREADY_O & ~mapped;
        end
    end

    // staged registers; all reset to control role with no-operation
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            for (int p = 0; p < NPIN; p++) begin
                fn_reg[p] <= '0;
            end
            mode_reg <= '0;
            str_reg <= '0;
        end else if (wr_en) begin
            if (idx == IDX_MODE_LO) begin
                mode_reg[7:0] <= PWDATA_I[7:0];
            end
            if (idx == IDX_MODE_HI) begin
                mode_reg[2*NPIN-1:8] <= PWDATA_I[5:0];
            end
            if (fn_write) begin
                fn_reg[3'(idx - IDX_FN_FIRST)] <= PWDATA_I[7:0];
            end
            if (idx == IDX_STRENGTH) begin
                str_reg <= PWDATA_I[NPIN-1:0];
            end
        end
    end

    //--------------------------------------------------------------
    // update: software strobe or rising edge of pin-driven update
    //--------------------------------------------------------------
    assign update = sw_update | (comb[FN_IO_UPDATE] & ~upd_pin_last);

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            for (int p = 0; p < NPIN; p++) begin
                fn_act[p] <= '0;
            end
            mode_act <= '0;
            str_act <= '0;
            upd_pin_last <= 1'b0;
        end else begin
            upd_pin_last <= comb[FN_IO_UPDATE];
            if (update) begin
                fn_act <= fn_reg;
                mode_act <= mode_reg;
                str_act <= str_reg;
            end
        end
    end

    // freeze set beats the clearing update in the same cycle
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            freeze <= 1'b0;
        end else if (fn_write && (~&dir_v)) begin
            freeze <= 1'b1;
        end else if (update) begin
            freeze <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // pin synchroniser: a change counts once stages two and three agree
    //--------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pin_val <= '0;
        end else begin
            sync1 <= PINS.level;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_val <= (sync3 & ~(sync2 ^ sync3))
                | (pin_val & (sync2 ^ sync3));
        end
    end

    //--------------------------------------------------------------
    // per-pin role decode and driver
    //--------------------------------------------------------------
    assign status_vec = {STATUS_I[NFUNC-1:2], 1'b1, 1'b0};

    genvar p;
    for (p = 0; p < NPIN; p++) begin : g_pin
        logic asrt;
        logic [MODE_W-1:0] md;
        assign dir_v[p] = fn_act[p][DIR_BIT];
        assign md = mode_act[2*p+1:2*p];
        assign inv_v[p] = md[COMB_INV_BIT];
        assign or_v[p] = md[COMB_OR_BIT];
        assign asrt = status_vec[fn_act[p][CODE_W-1:0]];
        // eeprom master overrides on pins 1 and 2; controls never drive
        always_ff @(posedge CLK_I) begin
            if (!NRST_I) begin
                PINS.dev_oe[p] <= 1'b0;
                PINS.dev_out[p] <= 1'b0;
                PINS.dev_weak[p] <= 1'b0;
            end else if (EE_PIN_MASK[p] && EE_OE_I[p]) begin
                PINS.dev_oe[p] <= 1'b1;
                PINS.dev_out[p] <= EE_OUT_I[p];
                PINS.dev_weak[p] <= 1'b0;
            end else if (dir_v[p]) begin
                PINS.dev_weak[p] <= str_act[p];
                case (md)
                    DRV_CMOS_HIGH: begin
                        PINS.dev_oe[p] <= 1'b1;
                        PINS.dev_out[p] <= asrt;
                    end
                    DRV_CMOS_LOW: begin
                        PINS.dev_oe[p] <= 1'b1;
                        PINS.dev_out[p] <= ~asrt;
                    end
                    DRV_OD_HIGH: begin
                        PINS.dev_oe[p] <= asrt;
                        PINS.dev_out[p] <= 1'b1;
                    end
                    default: begin
                        PINS.dev_oe[p] <= asrt;
                        PINS.dev_out[p] <= 1'b0;
                    end
                endcase
            end else begin
                PINS.dev_oe[p] <= 1'b0;
                PINS.dev_out[p] <= 1'b0;
                PINS.dev_weak[p] <= 1'b0;
            end
        end
    end

    //--------------------------------------------------------------
    // control combine per function: or group first, then and
    //--------------------------------------------------------------
    assign comb[FN_NO_OPERATION_FUNCTION] = 1'b0;
    genvar f;
    for (f = 1; f < NFUNC; f++) begin : g_fn
        logic [NPIN-1:0] sel, lvl, or_sel, and_sel;
        for (genvar q = 0; q < NPIN; q++) begin : g_sel
            assign sel[q] = ~dir_v[q]
                && fn_act[q][CODE_W-1:0] == CODE_W'(f);
        end
        assign lvl = pin_val ^ inv_v;
        assign or_sel = sel & or_v;
        assign and_sel = sel & ~or_v;
        assign comb[f] = (|sel) & (~(|or_sel) | (|(or_sel & lvl)))
            & (&(~and_sel | lvl));
    end

    // controls held while frozen so a rewrite cannot glitch them
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            CTRL_O <= '0;
        end else if (!freeze) begin
            CTRL_O <= comb;
        end
    end

    //--------------------------------------------------------------
    // straps: sampled once after reset, later levels ignored
    //--------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            strap_cnt <= '0;
            STRAP_VALID_O <= 1'b0;
            EEPROM_LOAD_O <= 1'b0;
            I2C_MODE_O <= 1'b0;
            I2C_ADDR_O <= I2C_ADDR_BASE;
        end else if (!STRAP_VALID_O) begin
            strap_cnt <= strap_cnt + 8'h01;
            if (strap_cnt == STRAP_CYC_W) begin
                STRAP_VALID_O <= 1'b1;
                EEPROM_LOAD_O <= pin_val[PIN_EE_LOAD];
                I2C_MODE_O <= pin_val[PIN_SER_MODE];
                I2C_ADDR_O <= {I2C_ADDR_BASE[6:2],
                    pin_val[PIN_ADDR_HI], pin_val[PIN_ADDR_LO]};
            end
        end
    end
endmodule : mfpin_device

// [hdl/mfpin_pkg.sv]
// constants shared by both ends of the multifunction pin link
// assumes a 125 MHz core clock and 32-bit apb register access
package mfpin_pkg;
    //--------------------------------------------------------------
    // geometry
    //--------------------------------------------------------------
    localparam int NPIN = 7;
    localparam int NFUNC = 128;
    localparam int CODE_W = 7;
    localparam int DIR_BIT = 7;
    localparam int MODE_W = 2;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    //--------------------------------------------------------------
    // device register indices, byte address is index times four
    //--------------------------------------------------------------
    localparam logic [9:0] IDX_MODE_LO = 10'h100;
    localparam logic [9:0] IDX_MODE_HI = 10'h101;
    localparam logic [9:0] IDX_FN_FIRST = 10'h102;
    localparam logic [9:0] IDX_FN_LAST = 10'h108;
    localparam logic [9:0] IDX_STRENGTH = 10'h109;
    localparam logic [9:0] IDX_UPDATE = 10'h10A;
    localparam logic [9:0] IDX_STATUS = 10'h10B;
    localparam int MODE_LO_PINS = 4;
    //--------------------------------------------------------------
    // board side register indices
    //--------------------------------------------------------------
    localparam logic [9:0] IDX_DRV_VAL = 10'h000;
    localparam logic [9:0] IDX_DRV_EN = 10'h001;
    localparam logic [9:0] IDX_PIN_STATE = 10'h002;
    //--------------------------------------------------------------
    // function codes and pin roles
    //--------------------------------------------------------------
    localparam logic [CODE_W-1:0] FN_NO_OPERATION_FUNCTION = 7'h00;
    localparam logic [CODE_W-1:0] FN_IO_UPDATE = 7'h01;
    localparam logic [MODE_W-1:0] DRV_CMOS_HIGH = 2'h0;
    localparam logic [MODE_W-1:0] DRV_CMOS_LOW = 2'h1;
    localparam logic [MODE_W-1:0] DRV_OD_HIGH = 2'h2;
    localparam logic [MODE_W-1:0] DRV_OD_LOW = 2'h3;
    localparam int COMB_INV_BIT = 0;
    localparam int COMB_OR_BIT = 1;
    localparam logic [NPIN-1:0] EE_PIN_MASK = 7'h06;
    localparam int PIN_EE_LOAD = 3;
    localparam int PIN_SER_MODE = 4;
    localparam int PIN_ADDR_LO = 5;
    localparam int PIN_ADDR_HI = 6;
    localparam logic [NPIN-1:0] PULLDOWN_MASK = 7'h18;
    localparam logic [6:0] I2C_ADDR_BASE = 7'h48;
    //--------------------------------------------------------------
    // strap sampling window after reset release
    //--------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int STRAP_WAIT_NS = 100;
    localparam int STRAP_CYC = (STRAP_WAIT_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam logic [7:0] STRAP_CYC_W = 8'(STRAP_CYC);
endpackage : mfpin_pkg

// [hdl/mfpin_if.sv]
// pin bundle joining the device end and the board end
// resolves each pin level from the two drivers and the pull-downs
`timescale 1ns/1ps
interface mfpin_if;
    import mfpin_pkg::*;
    logic [NPIN-1:0] dev_out;
    logic [NPIN-1:0] dev_oe;
    logic [NPIN-1:0] dev_weak;
    logic [NPIN-1:0] brd_out;
    logic [NPIN-1:0] brd_oe;
    logic [NPIN-1:0] level;
    // device driver first, then board, then pull (pulled low when idle)
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            if (dev_oe[p]) begin
                level[p] = dev_out[p];
            end else if (brd_oe[p]) begin
                level[p] = brd_out[p];
            end else begin
                level[p] = 1'b0 & PULLDOWN_MASK[p];
            end
        end
    end
    modport device (input level, output dev_out, dev_oe, dev_weak);
    modport board (input level, output brd_out, brd_oe);
endinterface : mfpin_if

// [hdl/mfpin_board.sv]
// board end: external logic that drives or samples the seven pins
// assumes software orders it over apb; joins device via mfpin_if
`timescale 1ns/1ps
module mfpin_board
    import mfpin_pkg::*;
(
    input wire logic CLK_I, // core clock
    input wire logic NRST_I, // sync reset, low active
    mfpin_if.board PINS, // pin bundle
    input wire logic PSEL_I, // apb select
    input wire logic PENABLE_I, // apb enable
    input wire logic PWRITE_I, // apb direction
    input wire logic [ADDR_W-1:0] PADDR_I, // apb byte address
    input wire logic [DATA_W-1:0] PWDATA_I, // apb write data
    output logic PREADY_O, // apb ready
    output logic [DATA_W-1:0] PRDATA_O, // apb read data
    output logic PSLVERR_O // apb error, unmapped
);
    logic [9:0] idx;
    logic access;
    logic wr_en;
    logic mapped;
    logic [DATA_W-1:0] rd_val;
    logic [NPIN-1:0] drv_val, drv_en;
    logic [NPIN-1:0] sync1, sync2, sync3, pin_val;

    assign idx = PADDR_I[ADDR_W-1:2];
    assign access = PSEL_I & PENABLE_I;
    assign wr_en = access & PREADY_O & PWRITE_I;

    //--------------------------------------------------------------
    // apb slave, same one-wait timing as the device end
    //--------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        rd_val = '0;
        case (idx)
            IDX_DRV_VAL: rd_val[NPIN-1:0] = drv_val;
            IDX_DRV_EN: rd_val[NPIN-1:0] = drv_en;
            IDX_PIN_STATE: rd_val[NPIN-1:0] = pin_val;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            PREADY_O <= 1'b0;
            PRDATA_O <= '0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= access & ~PREADY_O;
            PRDATA_O <= (access & ~PREADY_O & ~PWRITE_I) ? rd_val : '0;
            PSLVERR_O <= access & ~PREADY_O & ~mapped;
        end
    end

    // software must release a pin before the device update
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            drv_val <= '0;
            drv_en <= '0;
        end else if (wr_en && idx == IDX_DRV_VAL) begin
            drv_val <= PWDATA_I[NPIN-1:0];
        end else if (wr_en && idx == IDX_DRV_EN) begin
            drv_en <= PWDATA_I[NPIN-1:0];
        end
    end

    // registered pin drive, no combinational path to the wire
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            PINS.brd_out <= '0;
            PINS.brd_oe <= '0;
        end else begin
            PINS.brd_out <= drv_val;
            PINS.brd_oe <= drv_en;
        end
    end

    // sampled pin state, three stages like the device end
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pin_val <= '0;
        end else begin
            sync1 <= PINS.level;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_val <= (sync3 & ~(sync2 ^ sync3))
                | (pin_val & (sync2 ^ sync3));
        end
    end
endmodule : mfpin_board

// [tb/mfpin_asserts.sv]
// concurrent checks on device pin enables, apb answers and straps
// assumes the test top wires it beside the pin bundle, device side
`timescale 1ns/1ps
module mfpin_asserts
    import mfpin_pkg::*;
(
    input wire logic CLK_I, // core clock
    input wire logic NRST_I, // device reset, low active
    input wire logic [NPIN-1:0] dev_oe, // device pin enables
    input wire logic PSEL_I, // apb select
    input wire logic PENABLE_I, // apb enable
    input wire logic PREADY_O, // apb ready
    input wire logic PSLVERR_O, // apb error
    input wire logic [DATA_W-1:0] PRDATA_O, // apb read data
    input wire logic [NFUNC-1:0] CTRL_O, // control destinations
    input wire logic EEPROM_LOAD_O, // strap load
    input wire logic I2C_MODE_O, // strap serial mode
    input wire logic [6:0] I2C_ADDR_O, // strap address
    input wire logic STRAP_VALID_O // straps captured
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    chk_pins_released: assert property (
        $rose(NRST_I) |-> dev_oe == '0 && CTRL_O == '0)
        else $error("pin driven or control set at reset release");
    chk_ready_wait: assert property (
        PSEL_I && $rose(PENABLE_I) |=> PREADY_O)
        else $error("ready not one cycle into access");
    chk_ready_pulse: assert property (
        PREADY_O |-> $past(PENABLE_I) ##1 !PREADY_O)
        else $error("ready outside access or longer than a cycle");
    chk_err_ready: assert property (
        PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    chk_rdata_idle: assert property (
        !PREADY_O |-> PRDATA_O == '0)
        else $error("read data outside answer");
    chk_strap_window: assert property (
        $rose(NRST_I) |-> !STRAP_VALID_O ##[8:20] STRAP_VALID_O)
        else $error("straps not captured in time");
    chk_strap_frozen: assert property (
        STRAP_VALID_O && $past(STRAP_VALID_O)
            |-> $stable({EEPROM_LOAD_O, I2C_MODE_O, I2C_ADDR_O}))
        else $error("strap result moved after capture");
    chk_addr_base: assert property (
        I2C_ADDR_O[6:2] == 5'h12)
        else $error("address outside 0x48..0x4B");
    chk_no_operation_function_idle: assert property (
        CTRL_O[0] == 1'b0)
        else $error("no-operation control driven");
endmodule : mfpin_asserts

// [tb/test_multifunction_status_control_pins.sv]
// self-checking bench: device and board ends joined by the pin bundle
// assumes apb slaves answer under 20 cycles; straps need ~14 cycles
`timescale 1ns/1ps
module test_multifunction_status_control_pins;
    import mfpin_pkg::*;
    logic clk, nrst_d, nrst_b, dsel, bsel, pen, pwr, e, rq_err;
    logic d_rdy, d_err, b_rdy, b_err, load, mode, sv;
    logic [11:0] pa;
    logic [31:0] pwd, d_rd, b_rd, rq;
    logic [127:0] stat, ctrl;
    logic [6:0] ee_oe, ee_out, addr;
    logic [6:0] s_in [4] = '{7'h00, 7'h70, 7'h28, 7'h48};
    logic [8:0] s_ex [4] = '{9'h048, 9'h0CB, 9'h149, 9'h14A};
    logic eo, ev;
    int mismatches = 0;
    int samples_checked = 0;

    mfpin_if pins_if();
    mfpin_device mfpin_device_i(.CLK_I(clk), .NRST_I(nrst_d),
        .PINS(pins_if), .PSEL_I(dsel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(pa), .PWDATA_I(pwd), .PREADY_O(d_rdy), .PRDATA_O(d_rd),
        .PSLVERR_O(d_err), .STATUS_I(stat), .CTRL_O(ctrl),
        .EE_OE_I(ee_oe), .EE_OUT_I(ee_out), .EEPROM_LOAD_O(load),
        .I2C_MODE_O(mode), .I2C_ADDR_O(addr), .STRAP_VALID_O(sv));
    mfpin_board mfpin_board_i(.CLK_I(clk), .NRST_I(nrst_b),
        .PINS(pins_if), .PSEL_I(bsel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(pa), .PWDATA_I(pwd), .PREADY_O(b_rdy), .PRDATA_O(b_rd),
        .PSLVERR_O(b_err));
    mfpin_asserts mfpin_asserts_i(.CLK_I(clk), .NRST_I(nrst_d),
        .dev_oe(pins_if.dev_oe), .PSEL_I(dsel), .PENABLE_I(pen),
        .PREADY_O(d_rdy), .PSLVERR_O(d_err), .PRDATA_O(d_rd),
        .CTRL_O(ctrl), .EEPROM_LOAD_O(load), .I2C_MODE_O(mode),
        .I2C_ADDR_O(addr), .STRAP_VALID_O(sv));

    // free-running core clock, 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    //------------------------------------------------------------------
    // tasks
    //------------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string w, input logic [31:0] x,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", w, x, g);
        end
    endtask : chk

    // one apb transfer to device (b=0) or board (b=1); bounded wait
    task automatic acc(input bit b, input bit w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        dsel <= ~b;
        bsel <= b;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while ((b ? b_rdy : d_rdy) !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            test_done();
        end
        rq = b ? b_rd : d_rd;
        rq_err = b ? b_err : d_err;
        dsel <= 1'b0;
        bsel <= 1'b0;
        pen <= 1'b0;
    endtask : acc

    // new config shows on the pins one edge after the update lands
    task automatic upd();
        acc(0, 1, 12'h428, 32'h1);
        repeat (3) @(posedge clk);
    endtask : upd

    task automatic wait_sv();
        int n = 0;
        while (sv !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk("strap valid", 1, sv);
        if (sv !== 1'b1) begin
            test_done();
        end
    endtask : wait_sv

    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        {nrst_d, nrst_b, dsel, bsel, pen, pwr} = '0;
        pa = '0;
        pwd = '0;
        stat = '0;
        ee_oe = '0;
        ee_out = '0;
        repeat (3) @(posedge clk);
        nrst_d <= 1'b1;
        nrst_b <= 1'b1;
        wait_sv();
        // released pins, register access, unmapped place
        chk("oe after reset", 0, pins_if.dev_oe);
        acc(0, 0, 12'h408, 0);
        chk("fn0 reset", 0, rq);
        acc(0, 0, 12'h42C, 0);
        chk("status reset", 32'h10, rq);
        acc(0, 1, 12'h404, 32'h2A);
        acc(0, 0, 12'h404, 0);
        chk("mode hi", 32'h2A, rq);
        acc(0, 0, 12'h430, 0);
        chk("unmapped err", 1, rq_err);
        chk("unmapped data", 0, rq);
        acc(1, 0, 12'h00C, 0);
        chk("board unmapped err", 1, rq_err);
        acc(0, 1, 12'h424, 32'h1);
        // status output in every mode, both source levels
        for (int m = 0; m < 4; m++) begin
            for (int a = 0; a < 2; a++) begin
                stat[3] <= a[0];
                acc(0, 1, 12'h400, m);
                acc(0, 1, 12'h408, 32'h83);
                upd();
                eo = (m < 2) ? 1'b1 : a[0];
                ev = (m == 0) ? a[0] : (m == 1) ? !a[0] : (m == 2);
                chk("oe0", eo, pins_if.dev_oe[0]);
                chk("out0", ev, pins_if.dev_out[0]);
                chk("weak0", 1, pins_if.dev_weak[0]);
                acc(1, 0, 12'h008, 0);
                chk("level0", eo & ev, rq[0]);
            end
        end
        // staged change keeps driving until update, then no-op releases
        acc(0, 1, 12'h408, 32'h00);
        repeat (3) @(posedge clk);
        chk("oe0 staged", 1, pins_if.dev_oe[0]);
        upd();
        chk("oe0 no_operation_function", 0, pins_if.dev_oe[0]);
        // control combine: pin0 and, pin1 inverted or, pin2 or
        acc(1, 1, 12'h004, 32'h7F);
        acc(0, 1, 12'h400, 32'h2C);
        for (int p = 0; p < 3; p++) begin
            acc(0, 1, 12'h408 + 12'(4 * p), 32'h05);
        end
        upd();
        for (int v = 0; v < 8; v++) begin
            acc(1, 1, 12'h000, v);
            repeat (8) @(posedge clk);
            chk("combine", (!v[1] || v[2]) && v[0], ctrl[5]);
        end
        // a function write freezes controls until the next update
        acc(1, 1, 12'h000, 32'h1);
        repeat (8) @(posedge clk);
        acc(0, 1, 12'h420, 32'h00);
        acc(1, 1, 12'h000, 32'h0);
        repeat (8) @(posedge clk);
        chk("frozen", 1, ctrl[5]);
        acc(0, 0, 12'h42C, 0);
        chk("freeze flag", 32'h30, rq);
        upd();
        repeat (8) @(posedge clk);
        chk("thawed", 0, ctrl[5]);
        // eeprom master drives pins 1 and 2 only
        ee_oe <= 7'h07;
        ee_out <= 7'h02;
        repeat (4) @(posedge clk);
        chk("ee oe", 7'h06, pins_if.dev_oe);
        chk("ee out", 2'b01, pins_if.dev_out[2:1]);
        ee_oe <= 7'h00;
        // pin 3 as update control; its rising edge applies staged pin 0
        acc(0, 1, 12'h414, 32'h01);
        upd();
        acc(0, 1, 12'h408, 32'h83);
        acc(1, 1, 12'h000, 32'h08);
        repeat (8) @(posedge clk);
        chk("pin update", 1, pins_if.dev_oe[0]);
        // strap table, then levels changed after capture
        for (int i = 0; i < 4; i++) begin
            acc(1, 1, 12'h000, s_in[i]);
            @(posedge clk);
            nrst_d <= 1'b0;
            repeat (3) @(posedge clk);
            nrst_d <= 1'b1;
            wait_sv();
            chk("straps", s_ex[i], {load, mode, addr});
            acc(1, 1, 12'h000, ~s_in[i]);
            repeat (8) @(posedge clk);
            chk("straps held", s_ex[i], {load, mode, addr});
        end
        test_done();
    end
endmodule : test_multifunction_status_control_pins
